/* common/sbf_defs.svh */
// register offsets, field positions, reset values and timing figures of the serial block
`ifndef SBF_DEFS_SVH
`define SBF_DEFS_SVH

`define SBF_OFS_CTRL1 8'h00
`define SBF_OFS_CTRL2 8'h04
`define SBF_OFS_RATE 8'h08
`define SBF_OFS_STATUS 8'h0c
`define SBF_OFS_DATA 8'h10
`define SBF_OFS_EVT 8'h14
`define SBF_OFS_EVT_CLR 8'h18
`define SBF_OFS_EVT_EN 8'h1c

`define SBF_C1_IRQ_EN 7
`define SBF_C1_ENABLE 6
`define SBF_C1_CTRL_SEL 4
`define SBF_C1_CPOL 3
`define SBF_C1_CPHA 2
`define SBF_C2_MF_EN 4
`define SBF_SR_RX_FULL 7
`define SBF_SR_TX_EMPTY 5
`define SBF_SR_MODE_FAULT 4
`define SBF_RATE_PRE_LSB 4
`define SBF_RATE_SEL_LSB 0

`define SBF_EV_RX 0
`define SBF_EV_TX 1
`define SBF_EV_MF 2

`define SBF_CTRL1_RST 8'h04
`define SBF_CTRL2_RST 8'h00
`define SBF_RATE_RST 8'h00
`define SBF_EVT_EN_RST 3'h7

`define SBF_BITS_PER_BYTE 5'h10
`define SBF_CLK_NS 4

`endif

/* common/sbf_pkg.sv */
// types shared by the serial rate and status block
package sbf_pkg;
	typedef logic [7:0] sbf_addr_t;
	typedef logic [7:0] sbf_byte_t;
	typedef enum logic [0:0] {
		SBF_IDLE = 1'b0,
		SBF_BUSY = 1'b1
	} sbf_state_t;
endpackage

/* rtl/sbf_core.sv */
// serial link rate divider, transfer engine, status flags and wishbone register slave
//
// Implementation choices: register access over Wishbone and the address map.
`include "sbf_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sbf_core (
	// clock, reset, enable
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CLK_EN,
	// wishbone slave
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire sbf_pkg::sbf_addr_t WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK,
	// serial pins
	output logic SCK_O,
	output logic SCK_OE,
	output logic MOSI_O,
	output logic MOSI_OE,
	input wire logic MISO_I,
	input wire logic SS_N_I,
	// interrupt
	output logic IRQ
);
	import sbf_pkg::*;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	// pin synchronisers: a change counts once stages two and three agree
	logic [2:0] miso_sync_q, ss_sync_q;
	logic miso_f_q, ss_f_q;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			miso_sync_q <= 3'h0;
			ss_sync_q <= 3'h7;
			miso_f_q <= 1'b0;
			ss_f_q <= 1'b1;
		end else if (CLK_EN) begin
			miso_sync_q <= {miso_sync_q[1:0], MISO_I};
			ss_sync_q <= {ss_sync_q[1:0], SS_N_I};
			if (miso_sync_q[1] == miso_sync_q[2]) begin
				miso_f_q <= miso_sync_q[2];
			end
			if (ss_sync_q[1] == ss_sync_q[2]) begin
				ss_f_q <= ss_sync_q[2];
			end
		end
	end

	// bus decode
	logic ack_q, acc_w, wr_w, rd_w;
	logic [31:0] dat_q;
	sbf_addr_t word_adr;
	assign word_adr = {WB_ADR[7:2], 2'b00};
	assign acc_w = WB_CYC & WB_STB & ~ack_q;
	assign wr_w = acc_w & WB_WE & WB_SEL[0];
	assign rd_w = acc_w & ~WB_WE;
	wire wr_ctrl1 = wr_w && (word_adr == `SBF_OFS_CTRL1);
	wire wr_ctrl2 = wr_w && (word_adr == `SBF_OFS_CTRL2);
	wire wr_rate = wr_w && (word_adr == `SBF_OFS_RATE);
	wire wr_data = wr_w && (word_adr == `SBF_OFS_DATA);
	wire wr_evclr = wr_w && (word_adr == `SBF_OFS_EVT_CLR);
	wire wr_even = wr_w && (word_adr == `SBF_OFS_EVT_EN);
	wire rd_status = rd_w && (word_adr == `SBF_OFS_STATUS);
	wire rd_data = rd_w && (word_adr == `SBF_OFS_DATA);
	wire wr_status = wr_w && (word_adr == `SBF_OFS_STATUS);

	// control state
	sbf_byte_t ctrl1_q, ctrl2_q, rate_q;
	logic [2:0] evt_q, evt_en_q;
	wire irq_en = ctrl1_q[`SBF_C1_IRQ_EN];
	wire enable = ctrl1_q[`SBF_C1_ENABLE];
	wire master = ctrl1_q[`SBF_C1_CTRL_SEL];
	wire cpol = ctrl1_q[`SBF_C1_CPOL];
	wire cpha = ctrl1_q[`SBF_C1_CPHA];
	wire mf_en = ctrl2_q[`SBF_C2_MF_EN];
	wire [2:0] pre = rate_q[`SBF_RATE_PRE_LSB +: 3];
	wire [2:0] sel = rate_q[`SBF_RATE_SEL_LSB +: 3];

	// half the divisor: (pre+1) << sel, so the full period is (pre+1) << (sel+1)
	logic [10:0] half_w;
	assign half_w = 11'((11'(pre) + 11'h001) << sel);

	// status flags
	logic rx_full_q, tx_empty_q, mf_q;
	logic rx_arm_q, tx_arm_q, mf_arm_q;
	sbf_byte_t rx_data_q, tx_hold_q;

	// transfer engine state
	sbf_state_t st_q;
	logic [10:0] cnt_q, half_q;
	logic [4:0] edge_q;
	logic sck_q, mosi_q, rx_bit_q;
	sbf_byte_t shift_q;

	wire fault_w = master & enable & mf_en & ~ss_f_q;
	wire rate_chg = wr_rate && (WB_DAT_I[7:0] != rate_q);
	wire abort_w = fault_w | (master & rate_chg) | ~enable | ~master;
	wire busy = (st_q == SBF_BUSY);
	wire tick = busy && (cnt_q == 11'h000);
	logic [4:0] edge_nx;
	assign edge_nx = 5'(edge_q + 5'h01);
	wire sample_w = edge_nx[0] ^ cpha;
	wire last_w = tick && (edge_nx == `SBF_BITS_PER_BYTE);
	wire done_w = last_w && ~abort_w;
	sbf_byte_t rx_byte_w;
	assign rx_byte_w = {shift_q[6:0], cpha ? miso_f_q : rx_bit_q};
	wire start_w = ~busy && enable && master && ~tx_empty_q && ~fault_w;
	wire tx_take = wr_data && tx_arm_q && tx_empty_q;
	wire rx_set = done_w && ~rx_full_q;
	wire rx_clr = rd_data && rx_arm_q;
	wire mf_clr = wr_ctrl1 && mf_arm_q;

	// register read mux; unmapped words read as zero
	logic [31:0] rdata_w;
	assign rdata_w =
		(word_adr == `SBF_OFS_CTRL1) ? {24'h000000, ctrl1_q} :
		(word_adr == `SBF_OFS_CTRL2) ? {24'h000000, ctrl2_q} :
		(word_adr == `SBF_OFS_RATE) ? {24'h000000, rate_q} :
		(word_adr == `SBF_OFS_STATUS) ? {24'h000000, rx_full_q, 1'b0, tx_empty_q, mf_q, 4'h0} :
		(word_adr == `SBF_OFS_DATA) ? {24'h000000, rx_data_q} :
		(word_adr == `SBF_OFS_EVT) ? {29'h00000000, evt_q} :
		(word_adr == `SBF_OFS_EVT_EN) ? {29'h00000000, evt_en_q} :
		32'h00000000;

	// wishbone answer: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else if (CLK_EN) begin
			ack_q <= acc_w;
			if (rd_w) begin
				dat_q <= rdata_w;
			end
		end
	end

	// software registers; a mode fault overrides a write of controller select
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ctrl1_q <= `SBF_CTRL1_RST;
			ctrl2_q <= `SBF_CTRL2_RST;
			rate_q <= `SBF_RATE_RST;
			evt_en_q <= `SBF_EVT_EN_RST;
		end else if (CLK_EN) begin
			if (wr_ctrl1) begin
				ctrl1_q <= WB_DAT_I[7:0];
			end
			if (fault_w) begin
				ctrl1_q[`SBF_C1_CTRL_SEL] <= 1'b0;
			end
			if (wr_ctrl2) begin
				ctrl2_q <= {3'h0, WB_DAT_I[4], 4'h0};
			end
			if (wr_rate) begin
				rate_q <= {1'b0, WB_DAT_I[6:4], 1'b0, WB_DAT_I[2:0]};
			end
			if (wr_even) begin
				evt_en_q <= WB_DAT_I[2:0];
			end
		end
	end

	// status flags: every hardware set wins over the software clear in the same cycle
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rx_full_q <= 1'b0;
			tx_empty_q <= 1'b1;
			mf_q <= 1'b0;
			rx_arm_q <= 1'b0;
			tx_arm_q <= 1'b0;
			mf_arm_q <= 1'b0;
			rx_data_q <= 8'h00;
			tx_hold_q <= 8'h00;
		end else if (CLK_EN) begin
			rx_full_q <= rx_set | (rx_full_q & ~rx_clr);
			mf_q <= fault_w | (mf_q & ~mf_clr);
			// empty while the hold register has been handed to the shifter
			tx_empty_q <= start_w | (tx_empty_q & ~tx_take);
			// status writes fall through every branch here and leave flags alone
			rx_arm_q <= rd_status ? rx_full_q : (rx_arm_q & ~rd_data);
			tx_arm_q <= rd_status ? tx_empty_q : (tx_arm_q & ~wr_data);
			mf_arm_q <= rd_status ? mf_q : (mf_arm_q & ~wr_ctrl1);
			// an unserviced byte is kept; later bytes are lost
			if (rx_set) begin
				rx_data_q <= rx_byte_w;
			end
			if (tx_take) begin
				tx_hold_q <= WB_DAT_I[7:0];
			end
		end
	end

	// transfer engine: half-period delay, then sixteen clock edges
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_q <= SBF_IDLE;
			cnt_q <= 11'h000;
			half_q <= 11'h001;
			edge_q <= 5'h00;
			sck_q <= 1'b0;
		end else if (CLK_EN) begin
			if (abort_w) begin
				st_q <= SBF_IDLE;
				sck_q <= 1'b0;
			end else if (start_w) begin
				st_q <= SBF_BUSY;
				half_q <= half_w;
				cnt_q <= 11'(half_w - 11'h001);
				edge_q <= 5'h00;
			end else if (tick) begin
				sck_q <= ~sck_q;
				edge_q <= edge_nx;
				cnt_q <= 11'(half_q - 11'h001);
				if (last_w) begin
					st_q <= SBF_IDLE;
				end
			end else if (busy) begin
				cnt_q <= 11'(cnt_q - 11'h001);
			end
		end
	end

	// data path: sample on odd edges with phase 0, even edges with phase 1
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			shift_q <= 8'h00;
			mosi_q <= 1'b0;
			rx_bit_q <= 1'b0;
		end else if (CLK_EN) begin
			if (start_w) begin
				shift_q <= tx_hold_q;
				if (!cpha) begin
					mosi_q <= tx_hold_q[7];
				end
			end else if (tick && sample_w) begin
				rx_bit_q <= miso_f_q;
			end else if (tick && cpha && (edge_nx == 5'h01)) begin
				mosi_q <= shift_q[7];
			end else if (tick) begin
				shift_q <= {shift_q[6:0], rx_bit_q};
				mosi_q <= shift_q[6];
			end
		end
	end

	// sticky events, write-one-to-clear; a new event wins over its clear
	logic [2:0] evt_set;
	assign evt_set = {fault_w, start_w, rx_set};
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			evt_q <= 3'h0;
		end else if (CLK_EN) begin
			evt_q <= evt_set | (evt_q & ~(wr_evclr ? WB_DAT_I[2:0] : 3'h0));
		end
	end

	// registered outputs; pins are released while not controller or after a fault
	// data leaves with the same one-cycle lag as the clock, so it never moves on a sampling edge
	logic out_en_q, irq_q, sck_out_q, mosi_out_q;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			out_en_q <= 1'b0;
			irq_q <= 1'b0;
			sck_out_q <= 1'b0;
			mosi_out_q <= 1'b0;
		end else if (CLK_EN) begin
			mosi_out_q <= mosi_q;
			out_en_q <= enable & master & ~fault_w;
			irq_q <= irq_en & |(evt_set | (evt_q & evt_en_q));
			sck_out_q <= cpol ^ sck_q;
		end
	end

	assign WB_ACK = ack_q;
	assign WB_DAT_O = dat_q;
	assign SCK_O = sck_out_q;
	assign SCK_OE = out_en_q;
	assign MOSI_O = mosi_out_q;
	assign MOSI_OE = out_en_q;
	assign IRQ = irq_q;

	// checks; they assume CLK_EN stays high
	logic sck_prev_q;
	logic [11:0] gap_q;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sck_prev_q <= 1'b0;
			gap_q <= 12'h000;
		end else begin
			sck_prev_q <= sck_q;
			gap_q <= (sck_q != sck_prev_q) ? 12'h001 : 12'(gap_q + 12'h001);
		end
	end

	sequence s_status_saw_empty;
		rd_status && tx_empty_q;
	endsequence
	sequence s_byte_taken;
		!tx_empty_q && (tx_hold_q == $past(WB_DAT_I[7:0]));
	endsequence
	property p_half_period;
		(sck_q != sck_prev_q) && busy && (edge_q >= 5'h02) |-> gap_q == {1'b0, half_q};
	endproperty
	a_half_period: assert property (p_half_period) else $error("half period mismatch");
	property p_div_ends;
		((rate_q == 8'h00) |-> half_w == 11'h001) and ((rate_q == 8'h77) |-> half_w == 11'h400);
	endproperty
	a_div_ends: assert property (p_div_ends) else $error("divisor end values wrong");
	property p_rate_abort;
		busy && master && rate_chg |=> st_q == SBF_IDLE;
	endproperty
	a_rate_abort: assert property (p_rate_abort) else $error("rate change did not abort");
	property p_status_write;
		wr_status && !fault_w && !done_w && !start_w && !tx_take && !rx_clr && !mf_clr
			|=> $stable({rx_full_q, tx_empty_q, mf_q});
	endproperty
	a_status_write: assert property (p_status_write) else $error("status write changed flags");
	property p_rx_set;
		done_w && !rx_full_q |=> rx_full_q && rx_data_q == $past(rx_byte_w);
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("receive flag or data not set");
	property p_rx_keep;
		rx_full_q && rd_data && !rx_arm_q |=> rx_full_q;
	endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("receive flag cleared without arming");
	// a bus access takes two cycles at least, so the data write follows the status read later
	property p_tx_load;
		s_status_saw_empty ##[2:4] (wr_data && !rd_status) |=> s_byte_taken;
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("transmit byte not taken");
	property p_tx_ignore;
		wr_data && !tx_arm_q |=> $stable(tx_hold_q);
	endproperty
	a_tx_ignore: assert property (p_tx_ignore) else $error("unarmed data write accepted");
	property p_fault;
		fault_w |=> mf_q && !master && st_q == SBF_IDLE ##1 !SCK_OE && !MOSI_OE;
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault response wrong");
	property p_mf_clear;
		mf_q && mf_arm_q && wr_ctrl1 && !fault_w |=> !mf_q;
	endproperty
	a_mf_clear: assert property (p_mf_clear) else $error("mode fault not cleared");
	property p_mf_irq;
		fault_w && irq_en && !wr_ctrl1 |=> IRQ;
	endproperty
	a_mf_irq: assert property (p_mf_irq) else $error("mode fault raised no interrupt");

endmodule // sbf_core
`default_nettype wire

/* verification/sbf_peri_model.sv */
// serial peripheral model answering the block's controller transfers
`timescale 1ns/1ns
`default_nettype none
module sbf_peri_model #(parameter logic [7:0] REPLY = 8'h3c) (
	// serial link
	input wire logic SCK,
	input wire logic MOSI,
	input wire logic SEL_N,
	output logic MISO,
	// captured byte
	output logic [7:0] RX
);
	logic [7:0] tx_q;
	initial begin
		tx_q = REPLY;
		RX = 8'h00;
	end
	// the model only answers, so it never clocks the block at the divide-by-two rate
	always @(negedge SEL_N) tx_q = REPLY;
	always @(posedge SCK) RX = {RX[6:0], MOSI};
	always @(negedge SCK) tx_q = {tx_q[6:0], ~tx_q[7]};
	// deselected, the line shows the inverse of the bit rather than a held value
	assign MISO = SEL_N ? ~tx_q[7] : tx_q[7];
endmodule // sbf_peri_model
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the serial rate and status block
`include "sbf_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sbf_pkg::*;
	logic clk, rst, cyc, stb, we, ack, sck, sck_oe, mosi, mosi_oe, miso, ss_n, irq, sel_n;
	sbf_addr_t adr;
	logic [31:0] dat_i, dat_o, q;
	logic [7:0] prx;
	int errors, checks, cyc_n, n;
	sbf_core uut (.SYS_CLK(clk), .RST(rst), .CLK_EN(1'b1), .WB_CYC(cyc), .WB_STB(stb),
		.WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hf), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
		.WB_ACK(ack), .SCK_O(sck), .SCK_OE(sck_oe), .MOSI_O(mosi), .MOSI_OE(mosi_oe),
		.MISO_I(miso), .SS_N_I(ss_n), .IRQ(irq));
	sbf_peri_model peri (.SCK(sck), .MOSI(mosi), .SEL_N(sel_n), .MISO(miso), .RX(prx));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// the slowest rate alone needs some 17000 cycles
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 60000) begin
			errors = errors + 1;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input sbf_addr_t a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input string name, input sbf_addr_t a, input logic [31:0] exp);
		wb(1'b0, a, 0);
		chk(name, q, exp);
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		sel_n <= 1'b0;
		wb(1'b0, `SBF_OFS_STATUS, 0);
		wb(1'b1, `SBF_OFS_DATA, {24'h0, b});
	endtask
	// polls the sticky event bit so that the status arm stays untouched
	task automatic wait_rx();
		q = 0;
		while (q[`SBF_EV_RX] !== 1'b1) wb(1'b0, `SBF_OFS_EVT, 0);
		sel_n <= 1'b1;
	endtask
	task automatic next_edge();
		logic s;
		s = sck;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sck === s);
	endtask
	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge clk);
		chk("irq", irq, exp);
	endtask
	task automatic t_reset();
		rd("status", `SBF_OFS_STATUS, 32'h20);
		rd("rate", `SBF_OFS_RATE, 32'h0);
		rd("ctrl1", `SBF_OFS_CTRL1, 32'h4);
		rd("evt_en", `SBF_OFS_EVT_EN, 32'h7);
		rd("unmapped", 8'h3c, 32'h0);
		wb(1'b1, `SBF_OFS_STATUS, 0);
		rd("status after write", `SBF_OFS_STATUS, 32'h20);
	endtask
	// the data write inside send consumes the arm, so the second write must be dropped;
	// a slower rate leaves room for the input synchroniser before each sample
	task automatic t_unarmed();
		wb(1'b1, `SBF_OFS_CTRL1, 32'h50);
		wb(1'b1, `SBF_OFS_RATE, 32'h03);
		send(8'ha5);
		wb(1'b1, `SBF_OFS_DATA, 32'h11);
		rd("status unarmed", `SBF_OFS_STATUS, 32'h20);
	endtask
	task automatic t_xfer();
		wait_rx();
		chk("peer byte", prx, 8'ha5);
		rd("data", `SBF_OFS_DATA, 32'h3c);
		rd("status rx held", `SBF_OFS_STATUS, 32'ha0);
		rd("data again", `SBF_OFS_DATA, 32'h3c);
		rd("status rx clear", `SBF_OFS_STATUS, 32'h20);
		wb(1'b1, `SBF_OFS_EVT_CLR, 32'h7);
	endtask
	task automatic t_rate();
		logic [7:0] rates [3] = '{8'h00, 8'h12, 8'h77};
		int halves [3] = '{1, 8, 1024};
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, `SBF_OFS_RATE, {24'h0, rates[i]});
			send(8'hc3);
			next_edge();
			next_edge();
			chk("half period", n, halves[i]);
			wait_rx();
			chk("peer byte", prx, 8'hc3);
			wb(1'b0, `SBF_OFS_STATUS, 0);
			wb(1'b0, `SBF_OFS_DATA, 0);
			wb(1'b1, `SBF_OFS_EVT_CLR, 32'h7);
		end
	endtask
	task automatic t_abort();
		wb(1'b1, `SBF_OFS_RATE, 32'h03);
		send(8'h5a);
		next_edge();
		wb(1'b1, `SBF_OFS_RATE, 32'h02);
		n = 0;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			if (sck !== 1'b0) n++;
		end
		chk("sck after abort", n, 0);
		rd("evt after abort", `SBF_OFS_EVT, 32'h2);
		sel_n <= 1'b1;
	endtask
	task automatic t_fault();
		wb(1'b1, `SBF_OFS_EVT_CLR, 32'h7);
		wb(1'b1, `SBF_OFS_CTRL2, 32'h10);
		wb(1'b1, `SBF_OFS_CTRL1, 32'hd0);
		irq_chk(1'b0);
		ss_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("sck_oe", sck_oe, 1'b0);
		chk("mosi_oe", mosi_oe, 1'b0);
		chk("irq", irq, 1'b1);
		rd("ctrl1 after fault", `SBF_OFS_CTRL1, 32'hc0);
		rd("status fault", `SBF_OFS_STATUS, 32'h30);
		ss_n <= 1'b1;
		wb(1'b1, `SBF_OFS_CTRL1, 32'hc0);
		rd("status fault clear", `SBF_OFS_STATUS, 32'h20);
		wb(1'b1, `SBF_OFS_EVT_EN, 32'h0);
		irq_chk(1'b0);
		wb(1'b1, `SBF_OFS_EVT_EN, 32'h7);
		irq_chk(1'b1);
		wb(1'b1, `SBF_OFS_EVT_CLR, 32'h4);
		irq_chk(1'b0);
	endtask
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat_i = 32'h0;
		ss_n = 1'b1;
		sel_n = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_unarmed();
		t_xfer();
		t_rate();
		t_abort();
		t_fault();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
